// ==== rtl/char_rx_pkg.sv ====
// Purpose: Shared constants and types for the serial character receiver
// Assumes: 40 MHz system clock, classic Wishbone register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package char_rx_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SAMPLE_HZ = 880;
    localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam logic [2:0] SHIFT_COUNT = 3'h4;
    localparam logic [2:0] ZERO_COUNT = 3'h0;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DATA_OFFSET = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_LAST_BIT = 2;
    localparam logic CTRL_EN_RESET = 1'b0;
    localparam logic [7:0] PRESET_VALUE = 8'hff;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STOP_ONE = 2'h0,
        STOP_HALF = 2'h1,
        STOP_TWO = 2'h2
    } stop_mode_type;
    localparam logic [1:0] CTRL_MODE_RESET = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ACTIVE = 3'h2,
        ST_TAIL = 3'h4
    } rx_state_type;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_type;
    typedef struct packed {
        rx_state_type state;
        logic last;
        logic first;
        logic flag;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [15:0] div;
        logic tick;
        logic en;
        logic [1:0] mode;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] dout;
        logic act_out;
    } rx_regs_type;
endpackage : char_rx_pkg

// ==== rtl/serial_char_receiver.sv ====
// Purpose: Start-stop serial character receiver with Wishbone registers
// Assumes: SERIAL_IN synchronous to CLK_SYS; high is the stop (ground) level
// Notes:   Sampling runs at eight times the unit rate via a clock divider
//
// Functional notes
// - All receive timing comes from one 880 per second sampling tick.
// - Frame is start, eight data units, stop of one, one and a half or two units.
// - Stop level on the line keeps the receiver from activating.
// - Start level sets active on the next tick with one preset.
// - Preset loads register with ones, clears last flag and counter.
// - While active the unit counter advances each sampling tick.
// - At count four a single shift occurs while last is clear.
// - Stop level shifts in as one, so start enters as zero.
// - Shift that finds start zero in first stage sets last and done.
// - With last set, next count four ends activity, no shift.
// - Two unit stop: count one more cycle, clear last at count four.
// - One and a half stop: clear last at next count zero.
// - One unit stop: clear last together with active.
// - Counter stops with low bits zero when last clears.
// - Start of four ticks or shorter is rejected at first shift.
// - Each data output shows the stage true or inverted by option.
// - Optionally clear done flag when a new character starts.
// - Optionally show active state on a dedicated output.
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module serial_char_receiver #(
    parameter int unsigned SAMPLE_DIV_CYCLES = char_rx_pkg::SAMPLE_DIV,
    parameter logic [7:0] DATA_INVERT = 8'h00,
    parameter logic FLAG_CLEAR_ON_START = 1'b1,
    parameter logic ACTIVE_OUT_EN = 1'b1
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // Register bus
    input wire char_rx_pkg::wb_req_type WB_REQ,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Serial line
    input wire logic SERIAL_IN,
    // Character side
    output logic [7:0] CHAR_DATA,
    output logic CHAR_DONE,
    output logic RX_BUSY
);
    import char_rx_pkg::*;

    localparam logic [15:0] DIV_LOAD = 16'(SAMPLE_DIV_CYCLES - 1);

    rx_regs_type s_q;
    rx_regs_type s_d;
    logic [2:0] cnt_nx;
    logic req;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        cnt_nx = 3'(s_q.cnt + 3'h1);
        req = WB_REQ.cyc && WB_REQ.stb && !s_q.ack;
        // Sampling tick divider
        s_d.tick = (s_q.div == 16'h0);
        s_d.div = (s_q.div == 16'h0) ? DIV_LOAD : 16'(s_q.div - 16'h1);
        // Bus access first, so that hardware sets below win over clears
        s_d.ack = req;
        if (req && WB_REQ.we && WB_REQ.sel[0]) begin
            if (WB_REQ.adr == CTRL_OFFSET) begin
                s_d.en = WB_REQ.dat[CTRL_EN_BIT];
                s_d.mode = WB_REQ.dat[CTRL_MODE_LSB +: 2];
            end else if (WB_REQ.adr == STATUS_OFFSET) begin
                if (WB_REQ.dat[STAT_FLAG_BIT]) begin
                    s_d.flag = 1'b0;
                end
            end
        end
        if (req) begin
            if (WB_REQ.adr == CTRL_OFFSET) begin
                s_d.rdat = {29'h0, s_q.mode, s_q.en};
            end else if (WB_REQ.adr == STATUS_OFFSET) begin
                s_d.rdat = {29'h0, s_q.last, (s_q.state == ST_ACTIVE), s_q.flag};
            end else if (WB_REQ.adr == DATA_OFFSET) begin
                s_d.rdat = {24'h0, s_q.dout};
            end else begin
                s_d.rdat = 32'h0;
            end
        end
        // Receiver sequencing, one step per sampling tick
        if (s_q.tick) begin
            case (s_q.state)
                ST_IDLE: begin
                    // Stop level or disable holds the set gate off
                    if (s_q.en && !SERIAL_IN) begin
                        s_d.state = ST_ACTIVE;
                        s_d.sh = PRESET_VALUE;
                        s_d.last = 1'b0;
                        s_d.cnt = ZERO_COUNT;
                        s_d.first = 1'b1;
                        if (FLAG_CLEAR_ON_START) begin
                            s_d.flag = 1'b0;
                        end
                    end
                end
                ST_ACTIVE: begin
                    s_d.cnt = cnt_nx;
                    if (cnt_nx == SHIFT_COUNT) begin
                        if (!s_q.last) begin
                            s_d.sh = {SERIAL_IN, s_q.sh[7:1]};
                            s_d.first = 1'b0;
                            if (s_q.first && SERIAL_IN) begin
                                // Line went back to stop: treat as noise
                                s_d.state = ST_IDLE;
                            end else if (!s_q.sh[0]) begin
                                s_d.last = 1'b1;
                                s_d.flag = 1'b1;
                            end
                        end else if (s_q.mode == STOP_ONE) begin
                            s_d.state = ST_IDLE;
                            s_d.last = 1'b0;
                        end else begin
                            s_d.state = ST_TAIL;
                        end
                    end
                end
                ST_TAIL: begin
                    s_d.cnt = cnt_nx;
                    if ((s_q.mode == STOP_HALF) ? (cnt_nx == ZERO_COUNT)
                                                : (cnt_nx == SHIFT_COUNT)) begin
                        // Counter halts here with its low bits clear
                        s_d.last = 1'b0;
                        s_d.state = ST_IDLE;
                    end
                end
                default: begin
                    s_d.state = ST_IDLE;
                end
            endcase
        end
        s_d.dout = s_q.sh ^ DATA_INVERT;
        s_d.act_out = ACTIVE_OUT_EN && (s_d.state == ST_ACTIVE);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s_q.state <= ST_IDLE;
            s_q.last <= 1'b0;
            s_q.first <= 1'b0;
            s_q.flag <= 1'b0;
            s_q.cnt <= ZERO_COUNT;
            s_q.sh <= PRESET_VALUE;
            s_q.div <= 16'h0;
            s_q.tick <= 1'b0;
            s_q.en <= CTRL_EN_RESET;
            s_q.mode <= CTRL_MODE_RESET;
            s_q.ack <= 1'b0;
            s_q.rdat <= 32'h0;
            s_q.dout <= 8'h00;
            s_q.act_out <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign WB_DAT_O = s_q.rdat;
    assign WB_ACK_O = s_q.ack;
    assign CHAR_DATA = s_q.dout;
    assign CHAR_DONE = s_q.flag;
    assign RX_BUSY = s_q.act_out;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    logic shift_pt;
    assign shift_pt = s_q.tick && (s_q.state == ST_ACTIVE) && (s_q.cnt == 3'h3);
    logic start_pt;
    assign start_pt = s_q.tick && (s_q.state == ST_IDLE) && s_q.en && !SERIAL_IN;

    AST_START_PRESET: assert property (
        s_q.tick && s_q.state == ST_IDLE && s_q.en && !SERIAL_IN
        |=> s_q.state == ST_ACTIVE && s_q.sh == 8'hff && s_q.cnt == 3'h0 && !s_q.last)
        else $error("start did not activate with preset");
    AST_HOLD_ON_STOP: assert property (
        s_q.tick && s_q.state == ST_IDLE && (SERIAL_IN || !s_q.en) |=> s_q.state == ST_IDLE)
        else $error("receiver activated without start or enable");
    AST_COUNT_STEP: assert property (
        s_q.tick && s_q.state != ST_IDLE |=> s_q.cnt == 3'($past(s_q.cnt) + 3'h1))
        else $error("unit counter did not advance");
    AST_SHIFT_DATA: assert property (
        shift_pt && !s_q.last |=> s_q.sh == {$past(SERIAL_IN), $past(s_q.sh[7:1])})
        else $error("shift did not load the line level");
    AST_NO_SHIFT_LAST: assert property (
        shift_pt && s_q.last |=> $stable(s_q.sh) && s_q.state != ST_ACTIVE)
        else $error("activity did not end after last unit");
    AST_LAST_SET: assert property (
        shift_pt && !s_q.last && !s_q.first && !s_q.sh[0] |=> s_q.last && s_q.flag)
        else $error("character end not flagged");
    AST_NOISE: assert property (
        shift_pt && s_q.first && SERIAL_IN |=> s_q.state == ST_IDLE)
        else $error("short start not rejected");
    AST_ONE_UNIT: assert property (
        shift_pt && s_q.last && s_q.mode == STOP_ONE |=> s_q.state == ST_IDLE && !s_q.last)
        else $error("one unit stop did not clear last");
    AST_TAIL_END: assert property (
        s_q.tick && s_q.state == ST_TAIL && s_q.mode != STOP_HALF && s_q.cnt == 3'h3
        |=> s_q.state == ST_IDLE && !s_q.last)
        else $error("two unit stop did not end at count four");
    AST_HALF_END: assert property (
        s_q.tick && s_q.state == ST_TAIL && s_q.mode == STOP_HALF && s_q.cnt == 3'h7
        |=> s_q.state == ST_IDLE && !s_q.last)
        else $error("half unit stop did not end at count zero");
    AST_STOPPED: assert property (
        s_q.state == ST_IDLE |-> s_q.cnt[1:0] == 2'h0 && !s_q.last)
        else $error("counter stopped with low bits set");
    AST_DATA_OUT: assert property (
        1'b1 |=> CHAR_DATA == ($past(s_q.sh) ^ DATA_INVERT))
        else $error("character output mismatch");
    AST_TICK_GAP: assert property (
        s_q.tick |=> !s_q.tick)
        else $error("sampling tick lasted more than one cycle");
    AST_BUSY_OUT: assert property (
        1'b1 |-> RX_BUSY == (ACTIVE_OUT_EN && s_q.state == ST_ACTIVE))
        else $error("busy output does not follow active state");
    AST_DIV_RANGE: assert property (
        1'b1 |-> s_q.div <= DIV_LOAD)
        else $error("divider left its range");
    AST_NO_TICK: assert property (
        !s_q.tick |=> $stable(s_q.cnt) && $stable(s_q.state) && $stable(s_q.last))
        else $error("receiver moved without a sampling tick");
    AST_SH_HOLD: assert property (
        !shift_pt && !start_pt |=> $stable(s_q.sh))
        else $error("register changed outside a shift point");
    AST_CNT_IDLE: assert property (
        s_q.state == ST_IDLE && !start_pt |=> $stable(s_q.cnt))
        else $error("counter ran while stopped");
    AST_FIRST_SET: assert property (
        start_pt |=> s_q.first)
        else $error("start did not arm noise check");
    AST_FIRST_CLEARS: assert property (
        shift_pt && !s_q.last |=> !s_q.first)
        else $error("noise check stayed armed after first shift");
    AST_TAIL_LAST: assert property (
        s_q.state == ST_TAIL |-> s_q.last)
        else $error("tail without last unit");
    AST_TAIL_ENTRY: assert property (
        shift_pt && s_q.last && s_q.mode != STOP_ONE |=> s_q.state == ST_TAIL && s_q.last)
        else $error("long stop did not enter tail");
    AST_NO_START_TAIL: assert property (
        s_q.state == ST_TAIL |=> s_q.state != ST_ACTIVE)
        else $error("start taken during stop tail");
    AST_FLAG_RISE: assert property (
        $rose(s_q.flag) |-> $past(shift_pt))
        else $error("done flag set away from a shift");
    AST_LAST_RISE: assert property (
        $rose(s_q.last) |-> $past(shift_pt) && !$past(s_q.sh[0]))
        else $error("last unit set without start in first stage");
    AST_FLAG_START: assert property (
        FLAG_CLEAR_ON_START && start_pt |=> !s_q.flag)
        else $error("done flag kept at new start");
    AST_STATE_LEGAL: assert property (
        1'b1 |-> s_q.state inside {ST_IDLE, ST_ACTIVE, ST_TAIL})
        else $error("illegal receiver state");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    AST_ACK_REQ: assert property (
        req |=> s_q.ack)
        else $error("request not acknowledged");
    AST_ACK_ONE: assert property (
        s_q.ack |=> !s_q.ack)
        else $error("acknowledge lasted more than one cycle");
    AST_RD_CTRL: assert property (
        req && WB_REQ.adr == CTRL_OFFSET
        |=> WB_DAT_O == {29'h0, $past(s_q.mode), $past(s_q.en)})
        else $error("control read mismatch");
    AST_RD_STATUS: assert property (
        req && WB_REQ.adr == STATUS_OFFSET
        |=> WB_DAT_O[2:0] == {$past(s_q.last), $past(s_q.state == ST_ACTIVE), $past(s_q.flag)})
        else $error("status read mismatch");
    AST_RD_DATA: assert property (
        req && WB_REQ.adr == DATA_OFFSET |=> WB_DAT_O == {24'h0, $past(CHAR_DATA)})
        else $error("data read mismatch");
    AST_RD_OTHER: assert property (
        req && WB_REQ.adr != CTRL_OFFSET && WB_REQ.adr != STATUS_OFFSET
        && WB_REQ.adr != DATA_OFFSET |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    AST_RDAT_HOLD: assert property (
        !req |=> $stable(WB_DAT_O))
        else $error("read data changed without a request");
    AST_EN_WRITE: assert property (
        req && WB_REQ.we && WB_REQ.sel[0] && WB_REQ.adr == CTRL_OFFSET
        |=> s_q.en == $past(WB_REQ.dat[CTRL_EN_BIT])
        && s_q.mode == $past(WB_REQ.dat[CTRL_MODE_LSB +: 2]))
        else $error("control write lost");
    AST_CFG_HOLD: assert property (
        !(req && WB_REQ.we && WB_REQ.sel[0] && WB_REQ.adr == CTRL_OFFSET)
        |=> $stable(s_q.en) && $stable(s_q.mode))
        else $error("control changed without a write");
    // Software clear loses to a character completing in the same cycle
    AST_FLAG_CLEAR: assert property (
        req && WB_REQ.we && WB_REQ.sel[0] && WB_REQ.adr == STATUS_OFFSET
        && WB_REQ.dat[STAT_FLAG_BIT] && !shift_pt |=> !s_q.flag)
        else $error("done flag not cleared by write");
    AST_SET_WINS: assert property (
        req && WB_REQ.we && WB_REQ.adr == STATUS_OFFSET
        && shift_pt && !s_q.last && !s_q.first && !s_q.sh[0] |=> s_q.flag)
        else $error("clear beat the done flag set");

    COV_START: cover property (s_q.tick && s_q.state == ST_IDLE ##1 s_q.state == ST_ACTIVE);
    COV_DONE: cover property (!s_q.flag ##1 s_q.flag);
    COV_NOISE: cover property (shift_pt && s_q.first && SERIAL_IN);
    COV_TAIL: cover property (s_q.state == ST_TAIL ##1 s_q.state == ST_IDLE);
    COV_ONE_UNIT: cover property (shift_pt && s_q.last && s_q.mode == STOP_ONE);
endmodule : serial_char_receiver
`default_nettype wire

// ==== sim/line_sender.sv ====
// Purpose: Model of the line sender that drives start-stop characters
// Assumes: One unit lasts UNIT_CLKS clocks; high is the stop (ground) level
// Notes:   Line rests at the stop level between characters
`timescale 1ns/10ps
`default_nettype none
module line_sender #(
    parameter int UNIT_CLKS = 64
) (
    // Clock
    input wire logic clk,
    // Serial line
    output logic line
);
    // ------------------------------------------------------------
    // Character and noise generation
    // ------------------------------------------------------------
    initial line = 1'b1;

    // Start, eight data units first bit first, then stop units
    task automatic send_char(input logic [7:0] ch);
        logic [9:0] frame;
        frame = {1'b1, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk) line <= frame[i];
            repeat (UNIT_CLKS - 1) @(posedge clk);
        end
        // Extra stop units keep the rate within ten per second
        repeat (2 * UNIT_CLKS) @(posedge clk);
    endtask : send_char

    // Short start level, as line noise would give
    task automatic pulse_start(input int clks);
        @(posedge clk) line <= 1'b0;
        repeat (clks) @(posedge clk);
        line <= 1'b1;
    endtask : pulse_start
endmodule : line_sender
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the serial character receiver
// Assumes: Sampling divider shortened to 8 clocks per tick
// Notes:   Registers reached by classic Wishbone single cycles
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import char_rx_pkg::*;
    localparam int DIV = 8;
    localparam logic [7:0] INV = 8'h0f;
    logic clk_sys;
    logic rstn;
    wb_req_type wb;
    logic [31:0] rdata;
    logic ack;
    logic ser;
    logic [7:0] char_data;
    logic char_done;
    logic rx_busy;
    logic [31:0] rd;
    int bad_count;
    int check_count;

    serial_char_receiver #(.SAMPLE_DIV_CYCLES(DIV), .DATA_INVERT(INV)) dut (
        .CLK_SYS(clk_sys), .RSTN(rstn), .WB_REQ(wb), .WB_DAT_O(rdata), .WB_ACK_O(ack),
        .SERIAL_IN(ser), .CHAR_DATA(char_data), .CHAR_DONE(char_done), .RX_BUSY(rx_busy));
    line_sender #(.UNIT_CLKS(8 * DIV)) far (.clk(clk_sys), .line(ser));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys) wb <= '{1'b1, 1'b1, we, adr, 4'hf, wd};
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rd = rdata;
        wb <= '0;
    endtask : wb_cycle

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        check(rd, exp);
    endtask : rdchk

    task automatic rx_run(input logic [1:0] mode, input logic [7:0] ch);
        int n;
        int done_n;
        n = 0;
        done_n = 0;
        wb_cycle(1'b1, CTRL_OFFSET, {29'h0, mode, 1'b1});
        fork
            far.send_char(ch);
            begin
                while (rx_busy !== 1'b1 && n < 200) begin
                    @(posedge clk_sys);
                    n++;
                end
                repeat (2) @(posedge clk_sys);
                check({31'h0, char_done}, 32'h0);
                n = 2;
                while (rx_busy === 1'b1 && n < 2000) begin
                    @(posedge clk_sys);
                    n++;
                    if (char_done === 1'b1 && done_n == 0) done_n = n;
                end
                check(n, 608);
                check(n - done_n, 64);
                check({24'h0, char_data}, {24'h0, ch ^ INV});
                repeat (14) @(posedge clk_sys);
                rdchk(STATUS_OFFSET, {29'h0, mode != 2'h0, 2'b01});
                repeat (28) @(posedge clk_sys);
                rdchk(STATUS_OFFSET, {29'h0, mode == 2'h2, 2'b01});
                rdchk(DATA_OFFSET, {24'h0, ch ^ INV});
            end
        join
    endtask : rx_run

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        results();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        wb = '0;
        bad_count = 0;
        check_count = 0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(CTRL_OFFSET, 32'h4);
        rdchk(STATUS_OFFSET, 32'h0);
        wb_cycle(1'b1, 8'h20, 32'h1);
        rdchk(8'h20, 32'h0);
        rdchk(CTRL_OFFSET, 32'h4);
        // Receiver still disabled: the character must be ignored
        far.send_char(8'h5a);
        check({31'h0, char_done}, 32'h0);
        rdchk(STATUS_OFFSET, 32'h0);
        rx_run(2'h0, 8'h01);
        rx_run(2'h1, 8'hfe);
        rx_run(2'h2, 8'ha5);
        wb_cycle(1'b1, STATUS_OFFSET, 32'h1);
        rdchk(STATUS_OFFSET, 32'h0);
        // Two-tick start level is taken, then dropped at the first shift
        far.pulse_start(2 * DIV);
        check({31'h0, rx_busy}, 32'h1);
        repeat (40) @(posedge clk_sys);
        check({31'h0, rx_busy}, 32'h0);
        repeat (700) @(posedge clk_sys);
        rdchk(STATUS_OFFSET, 32'h0);
        check({31'h0, char_done}, 32'h0);
        results();
    end
endmodule : tb_top
`default_nettype wire
